// file: rtl/clk_pm_pkg.sv
/*
 * Constants, state encodings and carrier types for the system clock and
 * power mode controller.
 * Assumes a single 40 MHz bus clock; the two RC oscillators arrive as
 * free-running square waves on pins and are sampled in that domain.
 */
package clk_pm_pkg;

    localparam logic [7:0] OFS_FLAG_STATUS = 8'h00;
    localparam logic [7:0] OFS_CLK_SELECT = 8'h04;
    localparam logic [7:0] OFS_HS_OSC_CTRL = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    localparam int TO_BIT = 5;
    localparam int PDF_BIT = 4;
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 5;
    localparam int HS_KEEP_BIT = 1;
    localparam int LS_KEEP_BIT = 0;
    localparam int HS_STABLE_BIT = 1;
    localparam int HS_EN_BIT = 0;

    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_HS_STABLE = 1;
    localparam int IRQ_SWITCH_DONE = 2;

    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [2:0] SEL_SUB = 3'h7;
    localparam logic HS_EN_RST = 1'b1;
    localparam logic KEEP_RST = 1'b0;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // oscillator edges counted before a source is taken as stable
    localparam logic [7:0] HS_STABLE_EDGES = 8'h10;
    localparam logic [7:0] LS_STABLE_EDGES = 8'h04;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        PM_RUN = 5'h01,
        PM_SLEEP = 5'h02,
        PM_NAP_SUB_ON = 5'h04,
        PM_NAP_BOTH_ON = 5'h08,
        PM_NAP_HIGH_ON = 5'h10
    } pm_state_e;

    typedef enum logic [2:0] {
        SW_FOLLOW = 3'h1,
        SW_WAIT_OLD = 3'h2,
        SW_WAIT_NEW = 3'h4
    } sw_state_e;

    typedef struct packed {
        logic cpu_run;
        logic hs_osc_run;
        logic ls_osc_run;
        logic system_clock;
        logic high_clock;
        logic sub_clock;
        logic low_rc_clock;
    } clocks_s;

endpackage : clk_pm_pkg

// file: rtl/rc_edge_divider.sv
/*
 * Samples one RC oscillator pin and produces its filtered level plus
 * binary divided versions (taps 0..6 = divide by 1..64).
 * Assumes the pin is asynchronous and much slower than aclk/2.
 */
`timescale 1ns/1ps
`default_nettype none
module rc_edge_divider
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rc_pin,
    output logic [6:0] taps,
    output logic rise
);

    logic [2:0] sync_ff;
    logic level_ff;
    logic [5:0] cnt_ff;
    logic agree;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sync_ff <= 3'h0;
        else
            sync_ff <= {sync_ff[1:0], rc_pin};
    end

    // only the second and third stage are looked at
    assign agree = (sync_ff[1] == sync_ff[2]);
    assign rise = agree & sync_ff[2] & ~level_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            level_ff <= 1'b0;
        else if (agree)
            level_ff <= sync_ff[2];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_ff <= 6'h00;
        else if (rise)
            cnt_ff <= cnt_ff + 6'h01;
    end

    assign taps[0] = level_ff;
    genvar gi;
    generate
        for (gi = 1; gi < 7; gi++)
        begin : g_tap
            assign taps[gi] = cnt_ff[gi-1];
        end
    endgenerate

endmodule : rc_edge_divider
`default_nettype wire

// file: rtl/clk_glitch_free_mux.sv
/*
 * Glitch-free selection among eight clock levels sampled on aclk.
 * Assumes the requested source is toggling; a dead target would stall
 * the switch with the output held low.
 */
`timescale 1ns/1ps
`default_nettype none
module clk_glitch_free_mux
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] src,
    input wire logic [2:0] target,
    output logic clk_out,
    output logic [2:0] cur_sel,
    output logic switch_done
);

    clk_pm_pkg::sw_state_e state_ff;
    logic [2:0] sel_ff;
    logic [2:0] tgt_ff;
    logic [7:0] prev_ff;
    logic out_ff;
    logic done_ff;
    logic [7:0] fall;

    assign fall = prev_ff & ~src;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            prev_ff <= 8'h00;
        else
            prev_ff <= src;
    end

    // old source is parked low, then the new one is joined at its falling
    // edge so both phases that follow are full length
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= clk_pm_pkg::SW_FOLLOW;
            sel_ff <= clk_pm_pkg::SEL_RST;
            tgt_ff <= clk_pm_pkg::SEL_RST;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            case (state_ff)
                clk_pm_pkg::SW_FOLLOW:
                    if (target != sel_ff)
                    begin
                        tgt_ff <= target;
                        state_ff <= clk_pm_pkg::SW_WAIT_OLD;
                    end
                clk_pm_pkg::SW_WAIT_OLD:
                    if (!src[sel_ff])
                        state_ff <= clk_pm_pkg::SW_WAIT_NEW;
                clk_pm_pkg::SW_WAIT_NEW:
                    if (fall[tgt_ff])
                    begin
                        sel_ff <= tgt_ff;
                        done_ff <= 1'b1;
                        state_ff <= clk_pm_pkg::SW_FOLLOW;
                    end
                default:
                    state_ff <= clk_pm_pkg::SW_FOLLOW;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            out_ff <= 1'b0;
        else if (state_ff == clk_pm_pkg::SW_WAIT_NEW)
            out_ff <= 1'b0;
        else
            out_ff <= src[sel_ff];
    end

    assign clk_out = out_ff;
    assign cur_sel = sel_ff;
    assign switch_done = done_ff;

endmodule : clk_glitch_free_mux
`default_nettype wire

// file: rtl/system_clock_power_mode_ctrl.sv
/*
 * Clock source selection, halt/wake power modes, watchdog and power down
 * flags, with an AXI4-Lite register slave and one level interrupt.
 * Assumes the CPU core pulses halt, clear and wake for one aclk cycle and
 * that the watchdog gives its enable as a level on aclk.
 */
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module system_clock_power_mode_ctrl
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic high_speed_rc,
    input wire logic low_speed_rc,
    input wire logic halt_instr,
    input wire logic watchdog_clear_instr,
    input wire logic watchdog_timeout,
    input wire logic watchdog_enable,
    input wire logic wake_event,
    input wire logic [3:0] alu_flags,
    output clk_pm_pkg::clocks_s clocks,
    output logic irq
);

    logic [6:0] hs_taps;
    logic [6:0] ls_taps;
    logic hs_rise;
    logic ls_rise;
    logic mux_out;
    logic [2:0] mux_sel;
    logic switch_done;
    logic [2:0] mux_target;

    logic [2:0] clk_sel_ff;
    logic hs_keep_ff;
    logic ls_keep_ff;
    logic hs_en_ff;
    logic to_ff;
    logic pdf_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    logic [7:0] hs_cnt_ff;
    logic [7:0] ls_cnt_ff;
    logic hs_stable_prev_ff;
    logic sys_gate_ff;
    clk_pm_pkg::pm_state_e state_ff;
    clk_pm_pkg::clocks_s clocks_ff;
    clk_pm_pkg::clocks_s nxt_clocks;

    logic aw_hold_ff;
    logic w_hold_ff;
    logic [7:0] waddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic hs_stable;
    logic ls_stable;
    logic halt_taken;
    logic do_write;
    logic wr_en;
    logic rd_take;
    logic rd_clear;
    logic [2:0] irq_events;
    logic [7:0] nxt_rdata;
    logic nxt_rd_ok;
    logic hs_on;
    logic sub_on;
    logic low_speed_rc_on;
    logic sys_on;

    rc_edge_divider u_hs_div
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .rc_pin(high_speed_rc),
        .taps(hs_taps),
        .rise(hs_rise)
    );

    rc_edge_divider u_ls_div
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .rc_pin(low_speed_rc),
        .taps(ls_taps),
        .rise(ls_rise)
    );

    // the sub clock is the undivided low speed RC level
    clk_glitch_free_mux u_mux
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .src({ls_taps[0], hs_taps}),
        .target(mux_target),
        .clk_out(mux_out),
        .cur_sel(mux_sel),
        .switch_done(switch_done)
    );

    // stability counters restart whenever an oscillator is stopped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hs_cnt_ff <= 8'h00;
        else if (!clocks_ff.hs_osc_run)
            hs_cnt_ff <= 8'h00;
        else if (hs_rise && !hs_stable)
            hs_cnt_ff <= hs_cnt_ff + 8'h01;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ls_cnt_ff <= 8'h00;
        else if (!clocks_ff.ls_osc_run)
            ls_cnt_ff <= 8'h00;
        else if (ls_rise && !ls_stable)
            ls_cnt_ff <= ls_cnt_ff + 8'h01;
    end

    assign hs_stable = (hs_cnt_ff == clk_pm_pkg::HS_STABLE_EDGES);
    assign ls_stable = (ls_cnt_ff == clk_pm_pkg::LS_STABLE_EDGES);

    // an unready target leaves the mux on the clock it already runs
    always_comb
    begin
        mux_target = mux_sel;
        if (clk_sel_ff == clk_pm_pkg::SEL_SUB)
        begin
            if (ls_stable)
                mux_target = clk_sel_ff;
        end
        else if (hs_stable)
            mux_target = clk_sel_ff;
    end

    assign halt_taken = halt_instr && (state_ff == clk_pm_pkg::PM_RUN);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_ff <= clk_pm_pkg::PM_RUN;
        else
        begin
            case (state_ff)
                clk_pm_pkg::PM_RUN:
                    if (halt_taken)
                    begin
                        if (hs_keep_ff && ls_keep_ff)
                            state_ff <= clk_pm_pkg::PM_NAP_BOTH_ON;
                        else if (hs_keep_ff)
                            state_ff <= clk_pm_pkg::PM_NAP_HIGH_ON;
                        else if (ls_keep_ff)
                            state_ff <= clk_pm_pkg::PM_NAP_SUB_ON;
                        else
                            state_ff <= clk_pm_pkg::PM_SLEEP;
                    end
                clk_pm_pkg::PM_SLEEP,
                clk_pm_pkg::PM_NAP_SUB_ON,
                clk_pm_pkg::PM_NAP_BOTH_ON,
                clk_pm_pkg::PM_NAP_HIGH_ON:
                    if (wake_event)
                        state_ff <= clk_pm_pkg::PM_RUN;
                default:
                    state_ff <= clk_pm_pkg::PM_RUN;
            endcase
        end
    end

    always_comb
    begin
        hs_on = 1'b0;
        sub_on = 1'b0;
        low_speed_rc_on = 1'b1;
        sys_on = 1'b0;
        case (state_ff)
            clk_pm_pkg::PM_RUN:
            begin
                // FAST always needs the high RC; SLOW leaves it to software
                hs_on = (clk_sel_ff != clk_pm_pkg::SEL_SUB) || hs_en_ff;
                sub_on = 1'b1;
                sys_on = 1'b1;
            end
            clk_pm_pkg::PM_SLEEP:
                low_speed_rc_on = watchdog_enable;
            clk_pm_pkg::PM_NAP_SUB_ON:
            begin
                sub_on = 1'b1;
                sys_on = (clk_sel_ff == clk_pm_pkg::SEL_SUB);
            end
            clk_pm_pkg::PM_NAP_BOTH_ON:
            begin
                hs_on = 1'b1;
                sub_on = 1'b1;
                sys_on = 1'b1;
            end
            clk_pm_pkg::PM_NAP_HIGH_ON:
            begin
                hs_on = 1'b1;
                sys_on = (clk_sel_ff != clk_pm_pkg::SEL_SUB);
            end
            default:
                low_speed_rc_on = 1'b1;
        endcase
    end

    // gate only moves while the muxed clock is low, so no runt pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sys_gate_ff <= 1'b1;
        else if (!mux_out)
            sys_gate_ff <= sys_on;
    end

    always_comb
    begin
        nxt_clocks.cpu_run = (state_ff == clk_pm_pkg::PM_RUN);
        nxt_clocks.hs_osc_run = hs_on;
        nxt_clocks.ls_osc_run = low_speed_rc_on;
        nxt_clocks.system_clock = mux_out & sys_gate_ff;
        nxt_clocks.high_clock = hs_taps[0] & hs_on & hs_stable;
        nxt_clocks.sub_clock = ls_taps[0] & sub_on;
        nxt_clocks.low_rc_clock = ls_taps[0] & low_speed_rc_on;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clocks_ff <= '0;
        else
            clocks_ff <= nxt_clocks;
    end

    assign clocks = clocks_ff;

    // flag sets win over clears arriving in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            to_ff <= 1'b0;
        else if (watchdog_timeout)
            to_ff <= 1'b1;
        else if (watchdog_clear_instr || halt_taken)
            to_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pdf_ff <= 1'b0;
        else if (halt_taken)
            pdf_ff <= 1'b1;
        else if (watchdog_clear_instr)
            pdf_ff <= 1'b0;
    end

    assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
    assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    assign wr_en = do_write & wstrb0_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            waddr_ff <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr;
        end
        else if (do_write)
            aw_hold_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_hold_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
        end
        else if (do_write)
            w_hold_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= clk_pm_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_ff <= 1'b1;
            if (waddr_ff[7:2] > clk_pm_pkg::OFS_IRQ_MASK[7:2]
                || waddr_ff[1:0] != 2'h0)
                bresp_ff <= clk_pm_pkg::RESP_SLVERR;
            else
                bresp_ff <= clk_pm_pkg::RESP_OKAY;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    // writes to the flag status or irq status word change nothing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_sel_ff <= clk_pm_pkg::SEL_RST;
            hs_keep_ff <= clk_pm_pkg::KEEP_RST;
            ls_keep_ff <= clk_pm_pkg::KEEP_RST;
            hs_en_ff <= clk_pm_pkg::HS_EN_RST;
            irq_mask_ff <= clk_pm_pkg::IRQ_MASK_RST;
        end
        else if (wr_en)
        begin
            if (waddr_ff == clk_pm_pkg::OFS_CLK_SELECT)
            begin
                clk_sel_ff <= wdata_ff[clk_pm_pkg::SEL_MSB:
                                       clk_pm_pkg::SEL_LSB];
                hs_keep_ff <= wdata_ff[clk_pm_pkg::HS_KEEP_BIT];
                ls_keep_ff <= wdata_ff[clk_pm_pkg::LS_KEEP_BIT];
            end
            else if (waddr_ff == clk_pm_pkg::OFS_HS_OSC_CTRL)
                hs_en_ff <= wdata_ff[clk_pm_pkg::HS_EN_BIT];
            else if (waddr_ff == clk_pm_pkg::OFS_IRQ_MASK)
                irq_mask_ff <= wdata_ff[2:0];
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    assign s_axi_arready = ~rvalid_ff;
    assign rd_take = s_axi_arvalid & ~rvalid_ff;
    assign rd_clear = rd_take && (s_axi_araddr == clk_pm_pkg::OFS_IRQ_STATUS);

    always_comb
    begin
        nxt_rdata = 8'h00;
        nxt_rd_ok = 1'b1;
        if (s_axi_araddr == clk_pm_pkg::OFS_FLAG_STATUS)
            nxt_rdata = {2'h0, to_ff, pdf_ff, alu_flags};
        else if (s_axi_araddr == clk_pm_pkg::OFS_CLK_SELECT)
            nxt_rdata = {clk_sel_ff, 3'h0, hs_keep_ff, ls_keep_ff};
        else if (s_axi_araddr == clk_pm_pkg::OFS_HS_OSC_CTRL)
            nxt_rdata = {6'h00, hs_stable, hs_en_ff};
        else if (s_axi_araddr == clk_pm_pkg::OFS_IRQ_STATUS)
            nxt_rdata = {5'h00, irq_stat_ff};
        else if (s_axi_araddr == clk_pm_pkg::OFS_IRQ_MASK)
            nxt_rdata = {5'h00, irq_mask_ff};
        else
            nxt_rd_ok = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= clk_pm_pkg::RESP_OKAY;
        end
        else if (rd_take)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, nxt_rdata};
            rresp_ff <= nxt_rd_ok ? clk_pm_pkg::RESP_OKAY
                                  : clk_pm_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hs_stable_prev_ff <= 1'b0;
        else
            hs_stable_prev_ff <= hs_stable;
    end

    always_comb
    begin
        irq_events = 3'h0;
        irq_events[clk_pm_pkg::IRQ_TIMEOUT] = watchdog_timeout;
        irq_events[clk_pm_pkg::IRQ_HS_STABLE] = hs_stable & ~hs_stable_prev_ff;
        irq_events[clk_pm_pkg::IRQ_SWITCH_DONE] = switch_done;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_stat_ff <= 3'h0;
        else
            irq_stat_ff <= (irq_stat_ff & {3{~rd_clear}}) | irq_events;
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule : system_clock_power_mode_ctrl
`default_nettype wire

// file: bench/clk_pm_monitor.sv
/* Checker for system_clock_power_mode_ctrl, watching only its ports.
   Assumes one aclk domain with synchronous active low aresetn. */
`timescale 1ns/1ps
`default_nettype none
module clk_pm_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_instr,
    input wire logic wake_event,
    input wire logic watchdog_enable,
    input wire clk_pm_pkg::clocks_s clocks
);
    // clocks are still all zero at the first edge after release
    logic up_ff;
    always_ff @(posedge aclk)
    begin
        up_ff <= aresetn;
    end
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_halt_stops_cpu: assert property (
        halt_instr && clocks.cpu_run |-> ##2 !clocks.cpu_run)
        else $error("cpu still running after halt");
    a_wake_runs_cpu: assert property (
        wake_event |-> ##2 clocks.cpu_run)
        else $error("cpu not running after wake");
    a_ls_off_sleep: assert property (
        up_ff && !clocks.ls_osc_run |-> !clocks.cpu_run && !clocks.hs_osc_run)
        else $error("low oscillator off outside sleep");
    a_wdog_keeps_ls: assert property (
        up_ff && $past(watchdog_enable) && $past(watchdog_enable, 2)
        |-> clocks.ls_osc_run) else $error("low oscillator off with watchdog");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && s_axi_rdata[31:8] == 24'h0) else $error("read answer wrong");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule : clk_pm_monitor
bind system_clock_power_mode_ctrl clk_pm_monitor u_mon
(
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .halt_instr, .wake_event, .watchdog_enable, .clocks
);
`default_nettype wire

// file: bench/rc_osc_model.sv
/* Behavioural pair of RC oscillators beside the controller.
   Each toggles only while its run enable is high, else rests low. */
`timescale 1ns/1ps
`default_nettype none
module rc_osc_model
(
    input wire logic hs_run,
    input wire logic ls_run,
    output logic hs_rc,
    output logic ls_rc
);
    initial hs_rc = 1'h0;
    initial ls_rc = 1'h0;
    always #62.5 hs_rc = hs_run ? ~hs_rc : 1'h0;
    always #15625 ls_rc = ls_run ? ~ls_rc : 1'h0;
endmodule : rc_osc_model
`default_nettype wire

// file: bench/system_clock_power_mode_ctrl_bench.sv
/* Self-checking bench: AXI4-Lite register calls and CPU event pulses.
   Oscillators come from rc_osc_model, driven by the block's enables. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module system_clock_power_mode_ctrl_bench;
    logic aclk = 1'h0, aresetn = 1'h0, watchdog_enable = 1'h0, irq;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] ev = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, high_speed_rc, low_speed_rc;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    clk_pm_pkg::clocks_s clocks;
    int error_cnt = 0, compares = 0;
    system_clock_power_mode_ctrl u_dut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .high_speed_rc, .low_speed_rc,
        .halt_instr(ev[0]), .watchdog_clear_instr(ev[1]),
        .watchdog_timeout(ev[2]), .wake_event(ev[3]), .watchdog_enable,
        .alu_flags(4'ha), .clocks, .irq
    );
    rc_osc_model u_osc
    (
        .hs_run(clocks.hs_osc_run), .ls_run(clocks.ls_osc_run),
        .hs_rc(high_speed_rc), .ls_rc(low_speed_rc)
    );
    initial forever #12.5 aclk = ~aclk;
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        report_and_stop();
    end
    // bready is raised one edge late so a waiting response is seen held
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_awvalid || s_axi_wvalid);
        @(posedge aclk);
        s_axi_bready <= 1'h1;
        do
            @(posedge aclk);
        while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, a > 8'h10 ? 2'h2 : 2'h0)
    endtask : axw
    task automatic rck(input logic [7:0] a, input logic [7:0] e,
        input logic [7:0] m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do
            @(posedge aclk);
        while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        @(posedge aclk);
        s_axi_rready <= 1'h1;
        do
            @(posedge aclk);
        while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        `CHK(s_axi_rdata[7:0] & m, e)
        `CHK(s_axi_rresp, a > 8'h10 ? 2'h2 : 2'h0)
    endtask : rck
    task automatic pulse(input logic [3:0] e);
        ev <= e;
        @(posedge aclk);
        ev <= 4'h0;
        repeat (4) @(posedge aclk);
    endtask : pulse
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rck(8'h00, 8'h0a, 8'hff);
        rck(8'h04, 8'h00, 8'hff);
        rck(8'h08, 8'h01, 8'hff);
        rck(8'h14, 8'h00, 8'hff);
        axw(8'h14, 8'h00);
        axw(8'h10, 8'h01);
        $display("test reset values done");
        for (int i = 0; i < 8; i++)
        begin
            watchdog_enable <= i[2];
            axw(8'h04, {6'h0, i[1:0]});
            pulse(4'h1);
            `CHK(clocks.cpu_run, 1'h0)
            `CHK(clocks.hs_osc_run, i[1])
            `CHK(clocks.ls_osc_run, |i[2:0])
            `CHK(clocks.sub_clock & ~i[0], 1'h0)
            `CHK(clocks.high_clock & ~i[1], 1'h0)
            pulse(4'h8);
            `CHK(clocks.cpu_run, 1'h1)
        end
        $display("test halt modes done");
        rck(8'h00, 8'h1a, 8'hff);
        pulse(4'h2);
        rck(8'h00, 8'h0a, 8'hff);
        rck(8'h0c, 8'h00, 8'h00);
        pulse(4'h4);
        `CHK(irq, 1'h1)
        rck(8'h00, 8'h2a, 8'hff);
        rck(8'h0c, 8'h01, 8'h01);
        @(posedge aclk);
        `CHK(irq, 1'h0)
        axw(8'h04, 8'h03);
        pulse(4'h1);
        pulse(4'h8);
        rck(8'h00, 8'h1a, 8'hff);
        $display("test flags done");
        axw(8'h10, 8'h04);
        rck(8'h0c, 8'h00, 8'h00);
        axw(8'h04, 8'hff);
        while (irq !== 1'h1)
            @(posedge aclk);
        rck(8'h04, 8'he3, 8'hff);
        rck(8'h0c, 8'h04, 8'h04);
        rck(8'h0c, 8'h00, 8'h04);
        $display("test slow switch done");
        // keep bits rewritten mid nap must not change the mode in force
        axw(8'h04, 8'he2);
        pulse(4'h1);
        axw(8'h04, 8'he1);
        // the gate may wait up to half a low RC period for a low phase
        repeat (800) @(posedge aclk);
        `CHK(clocks.system_clock, 1'h0)
        `CHK(clocks.sub_clock, 1'h0)
        `CHK(clocks.hs_osc_run, 1'h1)
        pulse(4'h8);
        `CHK(clocks.cpu_run, 1'h1)
        $display("test nap keep bits done");
        axw(8'h08, 8'h00);
        repeat (4) @(posedge aclk);
        `CHK(clocks.hs_osc_run, 1'h0)
        rck(8'h08, 8'h00, 8'hff);
        axw(8'h08, 8'h01);
        rck(8'h08, 8'h01, 8'hff);
        // sixteen 8 MHz edges plus synchronisers fit well inside 200
        repeat (200) @(posedge aclk);
        rck(8'h08, 8'h03, 8'hff);
        `CHK(clocks.hs_osc_run, 1'h1)
        $display("test high oscillator done");
        report_and_stop();
    end
endmodule : system_clock_power_mode_ctrl_bench
`default_nettype wire
